/* verilog/sim_status_pkg.sv */
// Constants and carrier types for card presence and status outputs.
// Assumes a single 250 MHz system clock and synchronous active-high reset.
package sim_status_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned WAKE_PULSE_MS  = 1000;
  localparam int unsigned WAKE_PULSE_CYC = WAKE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEBOUNCE_US    = 10;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic RST_HOTPLUG_EN  = 1'b1;
  localparam logic RST_INVERT_POL  = 1'b0;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic valid;      // Command strobe
    logic hotplug_en; // Continuous detection when set
    logic invert_pol; // Low level means inserted when set
  } hotplug_cfg_t;

  typedef struct packed {
    logic present;    // Card considered inserted
    logic start_init; // One-cycle request to initialise the card
    logic read_allow; // Card read access permitted
  } card_status_t;

  typedef enum logic [1:0] {
    CARD_STARTUP,
    CARD_ABSENT,
    CARD_PRESENT
  } card_state_t;

endpackage

/* verilog/sim_presence_status.sv */
// Card presence detection with hot-plug control, RF status LED and
// host wake pulse. Inputs are synchronous to sys_clk except the card
// switch, which is synchronised and debounced here.
//
// Summary of operation
// - Default polarity: high presence input means inserted, low means removed.
// - After reset hot-plug detection is on and presence is tracked continuously.
// - Card seen present: start initialisation, read card, then register.
// - Input inactive with detection on: card removed, no read access.
// - Host command can invert polarity so low level means inserted.
// - LED output low while RF is on, high while RF is off.
// - Data request drives wake output low for one second, else high.
`timescale 1ns/1ps
`default_nettype none

module sim_presence_status
  import sim_status_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_PULSE_CYC,
  parameter int unsigned DEB_CYCLES  = DEBOUNCE_CYC
)
(
  input  wire logic         sys_clk,           // System clock
  input  wire logic         rst,               // Sync reset, active high
  input  wire logic         card_presence_in,  // Slot switch level
  input  wire hotplug_cfg_t hotplug_config_cmd,// Host configuration
  input  wire logic         rf_on,             // RF function enabled
  input  wire logic         data_request,      // Pulse: data needs host
  output var  card_status_t card_status,       // Card state to firmware
  output var  logic         rf_status_led_n,   // LED drive, low = on
  output var  logic         host_wake_n        // Wake host, low pulse
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  // Wake check spans 8 cycles; debounce must outlast the synchroniser
  if (WAKE_CYCLES < 8 || DEB_CYCLES < 3)
  begin
    $error("Wake count below 8 or debounce count below 3");
  end
  localparam int CW = $clog2(WAKE_CYCLES + 1);
  localparam int DW = $clog2(DEB_CYCLES + 1);

  // ------------------------------------------------------------------
  // Configuration
  // ------------------------------------------------------------------
  logic hotplug_en_q, hotplug_en_d;
  logic invert_q,     invert_d;

  always_comb
  begin
    hotplug_en_d = hotplug_en_q;
    invert_d     = invert_q;
    if (hotplug_config_cmd.valid)
    begin
      hotplug_en_d = hotplug_config_cmd.hotplug_en;
      invert_d     = hotplug_config_cmd.invert_pol;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hotplug_en_q <= RST_HOTPLUG_EN;
      invert_q     <= RST_INVERT_POL;
    end
    else
    begin
      hotplug_en_q <= hotplug_en_d;
      invert_q     <= invert_d;
    end
  end

  // ------------------------------------------------------------------
  // Synchroniser and debounce
  // ------------------------------------------------------------------
  logic          sync1_q, sync2_q;
  logic          stable_q, stable_d;
  logic [DW-1:0] deb_cnt_q, deb_cnt_d;
  logic          deb_valid_q, deb_valid_d;

  // Level must hold for DEB_CYCLES before it is believed
  always_comb
  begin
    stable_d    = stable_q;
    deb_cnt_d   = deb_cnt_q + 1'b1;
    deb_valid_d = deb_valid_q;
    if (!deb_valid_q && sync2_q != stable_q)
    begin
      stable_d  = sync2_q;
      deb_cnt_d = '0;
    end
    else if (deb_valid_q && sync2_q == stable_q)
      deb_cnt_d = '0;
    else if (deb_cnt_q == DW'(DEB_CYCLES - 1))
    begin
      stable_d    = sync2_q;
      deb_cnt_d   = '0;
      deb_valid_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1_q     <= 1'b0;
      sync2_q     <= 1'b0;
      stable_q    <= 1'b0;
      deb_cnt_q   <= '0;
      deb_valid_q <= 1'b0;
    end
    else
    begin
      sync1_q     <= card_presence_in;
      sync2_q     <= sync1_q;
      stable_q    <= stable_d;
      deb_cnt_q   <= deb_cnt_d;
      deb_valid_q <= deb_valid_d;
    end
  end

  // Polarity applied after debounce so a flip takes effect at once
  logic present_lvl;
  assign present_lvl = stable_q ^ invert_q;

  // ------------------------------------------------------------------
  // Card state
  // ------------------------------------------------------------------
  card_state_t  state_q, state_d;
  card_status_t status_d;

  always_comb
  begin
    state_d  = state_q;
    status_d = '0;
    case (state_q)
      CARD_STARTUP:
      begin
        if (deb_valid_q)
          state_d = present_lvl ? CARD_PRESENT : CARD_ABSENT;
      end
      CARD_ABSENT:
      begin
        if (hotplug_en_q && present_lvl)
          state_d = CARD_PRESENT;
      end
      CARD_PRESENT:
      begin
        if (hotplug_en_q && !present_lvl)
          state_d = CARD_ABSENT;
      end
      default: state_d = CARD_STARTUP;
    endcase
    // Hot-plug off freezes CARD_PRESENT or CARD_ABSENT, whichever is current; start-up still resolves
    status_d.present    = (state_d == CARD_PRESENT);
    status_d.read_allow = (state_d == CARD_PRESENT);
    status_d.start_init = (state_d == CARD_PRESENT)
                          && (state_q != CARD_PRESENT);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q     <= CARD_STARTUP;
      card_status <= '0;
    end
    else
    begin
      state_q     <= state_d;
      card_status <= status_d;
    end
  end

  // ------------------------------------------------------------------
  // Status LED and host wake
  // ------------------------------------------------------------------
  logic [CW-1:0] wake_cnt_q, wake_cnt_d;
  logic          wake_n_d;
  logic          led_n_d;

  always_comb
  begin
    wake_cnt_d = wake_cnt_q;
    if (wake_cnt_q != '0)
      wake_cnt_d = wake_cnt_q - 1'b1;
    else if (data_request)
      wake_cnt_d = CW'(WAKE_CYCLES);
    // Requests during a pulse merge into it rather than stretch it
    wake_n_d = (wake_cnt_d == '0);
    led_n_d  = !rf_on;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wake_cnt_q      <= '0;
      host_wake_n     <= 1'b1;
      rf_status_led_n <= 1'b1;
    end
    else
    begin
      wake_cnt_q      <= wake_cnt_d;
      host_wake_n     <= wake_n_d;
      rf_status_led_n <= led_n_d;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_request;
    !rst && data_request && wake_cnt_q == '0;
  endsequence
  sequence s_wake_low;
    !host_wake_n [*8];
  endsequence

  property p_wake_start;
    @(posedge sys_clk) disable iff (rst)
      s_request |=> s_wake_low;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("Wake did not go low on request");

  property p_wake_end;
    @(posedge sys_clk) disable iff (rst)
      (wake_cnt_q == 1) |=> host_wake_n;
  endproperty
  a_wake_end: assert property (p_wake_end)
    else $error("Wake pulse did not end");

  property p_wake_idle;
    @(posedge sys_clk) disable iff (rst)
      (wake_cnt_q == '0 && !data_request) |=> host_wake_n;
  endproperty
  a_wake_idle: assert property (p_wake_idle)
    else $error("Wake low while idle");

  property p_led;
    @(posedge sys_clk) disable iff (rst)
      ##1 rf_status_led_n == !$past(rf_on);
  endproperty
  a_led: assert property (p_led)
    else $error("LED does not follow RF state");

  property p_no_read_absent;
    @(posedge sys_clk) disable iff (rst)
      (state_q == CARD_ABSENT) |-> !card_status.read_allow || $past(rst);
  endproperty
  a_no_read_absent: assert property (p_no_read_absent)
    else $error("Read allowed with card absent");

  property p_insert;
    @(posedge sys_clk) disable iff (rst)
      (state_q == CARD_ABSENT && hotplug_en_q && present_lvl)
        |=> card_status.start_init && card_status.present;
  endproperty
  a_insert: assert property (p_insert)
    else $error("Insertion did not start initialisation");

  property p_remove;
    @(posedge sys_clk) disable iff (rst)
      (state_q == CARD_PRESENT && hotplug_en_q && !present_lvl)
        |=> !card_status.present;
  endproperty
  a_remove: assert property (p_remove)
    else $error("Removal not seen");

  property p_frozen;
    @(posedge sys_clk) disable iff (rst)
      (!hotplug_en_q && state_q != CARD_STARTUP) |=> $stable(state_q);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("State changed with hot-plug off");

  property p_polarity;
    @(posedge sys_clk) disable iff (rst)
      (hotplug_en_q && state_q != CARD_STARTUP) |=>
        (state_q == CARD_PRESENT) == ($past(stable_q) != $past(invert_q));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("Presence polarity wrong");

  property p_debounce;
    @(posedge sys_clk) disable iff (rst)
      (deb_valid_q && sync2_q != stable_q)
        |=> $stable(stable_q) || $past(deb_cnt_q) == DW'(DEB_CYCLES - 1);
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("Debounced level changed early");

endmodule
`default_nettype wire

/* bench/slot_model.sv */
// Card slot switch model with contact chatter on every change.
// Assumes the bench moves inserted just after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module slot_model
(
  input  wire logic       sys_clk,          // Bench clock
  input  wire logic       inserted,         // Card physically in
  input  wire logic [2:0] chatter,          // Bounce edges per change
  output var  logic       card_presence_in  // Switch level, high = in
);
  logic       last_q  = 1'b0;
  logic [2:0] left_q  = 3'h0;
  logic       level_q = 1'b0;

  assign card_presence_in = level_q;

  // One-cycle chatter stays below the debounce time by design
  always @(posedge sys_clk)
  begin
    if (inserted !== last_q)
    begin
      last_q <= inserted;
      left_q <= chatter;
      level_q <= inserted;
    end
    else if (left_q != 3'h0)
    begin
      left_q <= left_q - 3'h1;
      level_q <= ~level_q;
    end
    else
      level_q <= last_q;
  end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for card presence, LED and host wake logic.
// Assumes short wake and debounce counts set at the instance.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sim_status_pkg::*;
  localparam int WAKE_CYC = 20;
  logic         sys_clk, rst, inserted, rf_on, data_request;
  logic         card_presence_in, rf_status_led_n, host_wake_n;
  logic [2:0]   chatter;
  hotplug_cfg_t cmd;
  card_status_t card_status, prev;
  card_status_t q[$];
  int           err_count, total_checks, cyc, seed;

  sim_presence_status #(.WAKE_CYCLES(WAKE_CYC), .DEB_CYCLES(4)) uut (
    .sys_clk(sys_clk), .rst(rst), .card_presence_in(card_presence_in),
    .hotplug_config_cmd(cmd), .rf_on(rf_on), .data_request(data_request),
    .card_status(card_status), .rf_status_led_n(rf_status_led_n),
    .host_wake_n(host_wake_n));

  slot_model slot (.sys_clk(sys_clk), .inserted(inserted),
    .chatter(chatter), .card_presence_in(card_presence_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk_status(input card_status_t e, input card_status_t a);
    total_checks++;
    if (a !== e)
    begin
      err_count++;
      $display("Error card_status exp %b got %b", e, a);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic a);
    total_checks++;
    if (a !== e)
    begin
      err_count++;
      $display("Error %s exp %b got %b", nm, e, a);
    end
  endtask

  task automatic chk_int(input string nm, input int e, input int a);
    total_checks++;
    if (a != e)
    begin
      err_count++;
      $display("Error %s exp %0d got %0d", nm, e, a);
    end
  endtask

  task automatic wait_q;
    for (int i = 0; i < 80 && q.size() != 0; i++)
      step(1);
    chk_int("pending notes", 0, q.size());
  endtask

  task automatic cfg(input logic en, input logic inv);
    cmd = '{valid: 1'b1, hotplug_en: en, invert_pol: inv};
    step(1);
    cmd.valid = 1'b0;
  endtask

  task automatic note_insert;
    q.push_back(3'b111);
    q.push_back(3'b101);
  endtask

  task automatic wake_test(input bit again);
    int n;
    n = 0;
    chk_bit("wake idle", 1'b1, host_wake_n);
    data_request = 1'b1;
    step(1);
    data_request = 1'b0;
    while (host_wake_n === 1'b0 && n < 100)
    begin
      n++;
      data_request = again && n == 5; // Must not stretch the pulse
      step(1);
    end
    data_request = 1'b0;
    chk_int("wake length", WAKE_CYC, n);
  endtask

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Every change of card_status must match the oldest note
  // Sampled mid-cycle, clear of the edge that launches it
  always @(negedge sys_clk)
  begin
    if (!rst && card_status !== prev)
    begin
      if (q.size() == 0)
        chk_status(prev, card_status);
      else
        chk_status(q.pop_front(), card_status);
    end
    prev = card_status;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      $display("Error timeout exp 5000 got %0d", cyc);
      end_of_test();
    end
  end

  initial
  begin
    seed = 42;
    rst = 1'b1;
    inserted = 1'b0;
    chatter = 3'h0;
    rf_on = 1'b0;
    data_request = 1'b0;
    cmd = '0;
    prev = '0;
    step(12);
    rst = 1'b0;
    step(20);
    $display("Test startup done");
    note_insert();
    chatter = 3'($random(seed));
    inserted = 1'b1;
    wait_q();
    q.push_back(3'b000);
    chatter = 3'($random(seed));
    inserted = 1'b0;
    wait_q();
    $display("Test hot-plug done");
    note_insert();
    cfg(1'b1, 1'b1);
    wait_q();
    q.push_back(3'b000);
    cfg(1'b1, 1'b0);
    wait_q();
    $display("Test polarity done");
    cfg(1'b0, 1'b0);
    inserted = 1'b1;
    step(40);
    note_insert();
    cfg(1'b1, 1'b0);
    wait_q();
    $display("Test detect off done");
    // Card held in across reset; start-up must read it with detection off
    note_insert();
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    cfg(1'b0, 1'b0);
    wait_q();
    $display("Test mid-run reset done");
    for (int i = 0; i < 8; i++)
    begin
      rf_on = 1'($random(seed));
      step(2);
      chk_bit("led", ~rf_on, rf_status_led_n);
    end
    $display("Test led done");
    wake_test(1'b0);
    wake_test(1'b1);
    $display("Test wake done");
    end_of_test();
  end
endmodule
`default_nettype wire
